// File: qdsc_device.sv
// Digital front end of the quad voltage-output converter.
// Assumes the host drives the link pins; no system clock exists here, the
// serial clock, frame select, load and clear pins time all state.
`timescale 1ns/1ns
`default_nettype none
module qdsc_device #(
	parameter int RES = qdsc_pkg::CODE_W_MAX   // Code width, 8, 10 or 12
) (
	qdsc_link_if.device                          link,
	input  wire logic                            chain_enable_i,
	output logic [qdsc_pkg::CH_N-1:0][RES-1:0]   dac_code_o,
	output logic [qdsc_pkg::CH_N-1:0]            ref_buf_o,
	output logic [qdsc_pkg::CH_N-1:0]            gain_o,
	output logic [qdsc_pkg::CH_N-1:0]            out_en_o,
	output logic                                 in_buf_on_o
);
	import qdsc_pkg::*;

	// One stored channel entry: gain, buffer select, code
	localparam int ENT_W = RES + 2;
	typedef logic [ENT_W-1:0] qdsc_ent_t;

	logic [CNT_W-1:0]  cnt;              // Falling edges in this frame
	logic [CNT_W-1:0]  next_cnt;
	logic [WORD_W-1:0] shreg;            // Input shift register
	logic [WORD_W-1:0] next_shreg;
	logic              full;             // A whole word is in shreg
	logic              next_full;
	logic              so_q;             // Serial output flop
	logic              next_so;
	qdsc_ent_t         in_reg [CH_N];    // Input registers
	qdsc_ent_t         next_in_reg [CH_N];
	qdsc_ent_t         held [CH_N];      // Converter registers
	qdsc_ent_t         next_held [CH_N];
	qdsc_ent_t         live [CH_N];      // Value each converter shows
	logic              shifting;         // Shift register accepts bits
	logic              framed;           // Frame select is low
	logic [CH_W-1:0]   word_ch;          // Addressed channel
	qdsc_ent_t         word_ent;         // Decoded entry of the word

	// Pull gain, buffer select and the left-aligned code from a word
	function automatic qdsc_ent_t decode_ent(
		input logic [WORD_W-1:0] w
	);
		decode_ent = {w[GAIN_POS], w[BUF_POS], w[DATA_MSB -: RES]};
	endfunction

	// Frame and shift qualification
	always_comb begin
		framed   = ~link.sync_n;
		// Standalone stops after 16 edges, chaining keeps shifting
		shifting = framed &&
			((cnt != BITS_FULL) || chain_enable_i);
		// Serial buffers live while shifting: whole frame when chained, to the 16th edge standalone
		in_buf_on_o = shifting;
	end

	// Next values of the shift-side state
	always_comb begin
		next_cnt   = cnt;
		next_shreg = shreg;
		next_full  = full;
		if (framed) begin
			// Count saturates so a long frame cannot wrap
			if (cnt != BITS_FULL) begin
				next_cnt = cnt + 5'h01;
			end
			// Full is set by the 16th edge, dropped by a new frame
			if (cnt == BITS_LAST) begin
				next_full = 1'b1;
			end else if (cnt == BITS_ZERO) begin
				next_full = 1'b0;
			end
		end
		if (shifting) begin
			next_shreg = {shreg[WORD_W-2:0], link.din};
		end
	end

	// Edge counter, cleared whenever the frame select is high.
	// A release before the 16th edge thus leaves full low: the abort.
	always_ff @(negedge link.sclk or posedge link.sync_n) begin
		if (link.sync_n) begin
			cnt <= BITS_ZERO;
		end else begin
			cnt <= next_cnt;
		end
	end

	// Shift register and word flag; no reset, so the last word stays
	// readable through the chain output
	always_ff @(negedge link.sclk) begin
		shreg <= next_shreg;
		full  <= next_full;
	end

	// Serial output takes the top bit on the rising edge
	always_comb begin
		next_so = shreg[WORD_W-1];
	end

	always_ff @(posedge link.sclk or negedge link.clear_all_n) begin
		if (!link.clear_all_n) begin
			so_q <= 1'b0;
		end else begin
			so_q <= next_so;
		end
	end

	// Standalone parts leave the line undriven and low
	always_comb begin
		link.serial_out_en = chain_enable_i;
		link.serial_out    = chain_enable_i ? so_q : 1'b0;
	end

	// Decode of the finished word
	always_comb begin
		word_ch  = shreg[CH_POS +: CH_W];
		word_ent = decode_ent(shreg);
	end

	// Input register update: only the addressed channel changes.
	// Committed at frame release so chained parts all update together;
	// full is stable then because the serial clock is idle.
	always_comb begin
		for (int i = 0; i < CH_N; i++) begin
			next_in_reg[i] = in_reg[i];
		end
		if (full) begin
			next_in_reg[word_ch] = word_ent;
		end
	end

	always_ff @(posedge link.sync_n or negedge link.clear_all_n) begin
		if (!link.clear_all_n) begin
			in_reg <= '{default: '0};
		end else begin
			in_reg <= next_in_reg;
		end
	end

	// Converter registers capture the input registers as load rises
	always_comb begin
		for (int i = 0; i < CH_N; i++) begin
			next_held[i] = in_reg[i];
		end
	end

	always_ff @(posedge link.load_outputs_n or negedge link.clear_all_n)
	begin
		if (!link.clear_all_n) begin
			held <= '{default: '0};
		end else begin
			held <= next_held;
		end
	end

	// Per-channel output stage.
	// While load is low the converter follows its input register, so a
	// pin tied low gives immediate update; rising load freezes it.
	// Clear zeroes both stores, so the output is zero in either case.
	generate
		for (genvar g = 0; g < CH_N; g++) begin : g_ch
			always_comb begin
				// Transparent while load is asserted
				live[g] = link.load_outputs_n ? held[g] : in_reg[g];
				// Unsigned straight-binary code
				dac_code_o[g] = live[g][RES-1:0];
				// Pairs A/B and C/D share a reference pin, chosen per channel
				ref_buf_o[g]  = live[g][RES];
				gain_o[g]     = live[g][RES+1];
				// Power-down pin floats every output
				out_en_o[g]   = link.power_down_n;
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: qdsc_host.sv
// Host controller for the quad converter link, with an AXI4-Lite slave.
// Assumes software writes a word and polls busy; the serial clock is
// made here by a divider from clk_i.
`timescale 1ns/1ns
`default_nettype none
module qdsc_host #(
	parameter int HALF = qdsc_pkg::HALF_DEF_CYC  // Clocks per half period
) (
	input  wire logic                        clk_i,
	input  wire logic                        sys_rst_i,
	input  wire logic [qdsc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output logic                             s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output logic                             s_axi_wready_o,
	output logic [1:0]                       s_axi_bresp_o,
	output logic                             s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	input  wire logic [qdsc_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output logic                             s_axi_arready_o,
	output logic [31:0]                      s_axi_rdata_o,
	output logic [1:0]                       s_axi_rresp_o,
	output logic                             s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i,
	qdsc_link_if.host                        link
);
	import qdsc_pkg::*;

	// Bus-side state
	logic [ADDR_W-1:0] awaddr_q, next_awaddr;   // Held write address
	logic              aw_q, next_aw_q;         // Address taken
	logic [31:0]       wdata_q, next_wdata;     // Held write data
	logic [3:0]        wstrb_q, next_wstrb;
	logic              w_q, next_w_q;           // Data taken
	logic              bvalid_q, next_bvalid;
	logic [1:0]        bresp_q, next_bresp;
	logic              rvalid_q, next_rvalid;
	logic [1:0]        rresp_q, next_rresp;
	logic [31:0]       rdata_q, next_rdata;
	logic [WORD_W-1:0] word_q, next_word;       // Word to send
	logic [PINS_W-1:0] pins_q, next_pins;       // Control pin levels
	logic              start_q, next_start;     // One-cycle launch
	logic              busy;

	// Link-side state
	qdsc_state_t       state, next_state;
	logic [PH_W-1:0]   phase, next_phase;       // Clocks left in phase
	logic [CNT_W-1:0]  bits, next_bits;         // Falling edges made
	logic [WORD_W-1:0] tx, next_tx;             // Outgoing bits
	logic [WORD_W-1:0] rsh, next_rsh;           // Incoming bits
	logic [WORD_W-1:0] rb_q, next_rb;           // Last read-back word
	logic              sclk_q, next_sclk;
	logic              sync_q, next_sync;
	logic              so_s1, so_s2;            // Serial-out synchroniser

	assign busy = (state != ST_IDLE) || start_q;

	// Channel readies; one write and one read at a time
	always_comb begin
		s_axi_awready_o = ~aw_q & ~bvalid_q;
		s_axi_wready_o  = ~w_q & ~bvalid_q;
		s_axi_arready_o = ~rvalid_q;
		s_axi_bvalid_o  = bvalid_q;
		s_axi_bresp_o   = bresp_q;
		s_axi_rvalid_o  = rvalid_q;
		s_axi_rresp_o   = rresp_q;
		s_axi_rdata_o   = rdata_q;
	end

	// Next values of the bus-side state
	always_comb begin
		next_aw_q   = aw_q;
		next_awaddr = awaddr_q;
		next_w_q    = w_q;
		next_wdata  = wdata_q;
		next_wstrb  = wstrb_q;
		next_bvalid = bvalid_q;
		next_bresp  = bresp_q;
		next_rvalid = rvalid_q;
		next_rresp  = rresp_q;
		next_rdata  = rdata_q;
		next_word   = word_q;
		next_pins   = pins_q;
		next_start  = 1'b0;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_aw_q   = 1'b1;
			next_awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_w_q   = 1'b1;
			next_wdata = s_axi_wdata_i;
			next_wstrb = s_axi_wstrb_i;
		end
		// Both halves present: perform the write
		if (aw_q && w_q) begin
			next_aw_q   = 1'b0;
			next_w_q    = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = RESP_OKAY;
			case (awaddr_q)
				OFF_WORD: begin
					// A word written while busy is dropped
					if (!busy) begin
						if (wstrb_q[0]) next_word[7:0]  = wdata_q[7:0];
						if (wstrb_q[1]) next_word[15:8] = wdata_q[15:8];
						next_start = 1'b1;
					end
				end
				OFF_PINS: begin
					if (wstrb_q[0]) next_pins = wdata_q[PINS_W-1:0];
				end
				OFF_STAT, OFF_RBK: begin
					// Read-only, write ignored
				end
				default: next_bresp = RESP_SLVERR;
			endcase
		end
		if (bvalid_q && s_axi_bready_i) begin
			next_bvalid = 1'b0;
		end
		if (rvalid_q && s_axi_rready_i) begin
			next_rvalid = 1'b0;
		end
		// Read data is latched when the address is taken
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			case (s_axi_araddr_i)
				OFF_WORD: next_rdata[WORD_W-1:0] = word_q;
				OFF_PINS: next_rdata[PINS_W-1:0] = pins_q;
				OFF_STAT: next_rdata[0] = busy;
				OFF_RBK:  next_rdata[WORD_W-1:0] = rb_q;
				default:  next_rresp = RESP_SLVERR;
			endcase
		end
	end

	// Bus-side registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			aw_q     <= 1'b0;
			awaddr_q <= '0;
			w_q      <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
			word_q   <= 16'h0000;
			pins_q   <= PINS_RST;
			start_q  <= 1'b0;
		end else begin
			aw_q     <= next_aw_q;
			awaddr_q <= next_awaddr;
			w_q      <= next_w_q;
			wdata_q  <= next_wdata;
			wstrb_q  <= next_wstrb;
			bvalid_q <= next_bvalid;
			bresp_q  <= next_bresp;
			rvalid_q <= next_rvalid;
			rresp_q  <= next_rresp;
			rdata_q  <= next_rdata;
			word_q   <= next_word;
			pins_q   <= next_pins;
			start_q  <= next_start;
		end
	end

	// Serial sequencer: frame select low, 16 clock pulses, gap.
	// HALF must stay at or above HALF_MIN_CYC to respect the clock limit,
	// and at 3 or more so read-back bits clear the synchroniser.
	always_comb begin
		next_state = state;
		next_phase = phase;
		next_bits  = bits;
		next_tx    = tx;
		next_rsh   = rsh;
		next_rb    = rb_q;
		next_sclk  = sclk_q;
		next_sync  = sync_q;
		case (state)
			ST_IDLE: begin
				if (start_q) begin
					next_state = ST_SHIFT;
					next_sync  = 1'b0;
					next_tx    = word_q;
					next_bits  = BITS_ZERO;
					next_phase = PH_W'(HALF - 1);
				end
			end
			ST_SHIFT: begin
				if (phase != '0) begin
					next_phase = phase - 4'h1;
				end else begin
					next_phase = PH_W'(HALF - 1);
					if (sclk_q) begin
						// Falling edge: device takes din, we take serial_out
						next_sclk = 1'b0;
						next_bits = bits + 5'h01;
						next_rsh  = {rsh[WORD_W-2:0], so_s2};
					end else if (bits == BITS_FULL) begin
						next_sclk  = 1'b1;
						next_sync  = 1'b1;
						next_rb    = rsh;
						next_state = ST_GAP;
						next_phase = PH_W'(SYNC_GAP_CYC - 1);
					end else begin
						next_sclk = 1'b1;
						next_tx   = {tx[WORD_W-2:0], 1'b0};
					end
				end
			end
			ST_GAP: begin
				if (phase != '0) begin
					next_phase = phase - 4'h1;
				end else begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Link-side registers and the serial-out synchroniser
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state  <= ST_IDLE;
			phase  <= '0;
			bits   <= BITS_ZERO;
			tx     <= 16'h0000;
			rsh    <= 16'h0000;
			rb_q   <= 16'h0000;
			sclk_q <= 1'b1;
			sync_q <= 1'b1;
			so_s1  <= 1'b0;
			so_s2  <= 1'b0;
		end else begin
			state  <= next_state;
			phase  <= next_phase;
			bits   <= next_bits;
			tx     <= next_tx;
			rsh    <= next_rsh;
			rb_q   <= next_rb;
			sclk_q <= next_sclk;
			sync_q <= next_sync;
			so_s1  <= link.serial_out;
			so_s2  <= so_s1;
		end
	end

	// Pins come straight from flops; load may simply stay low
	always_comb begin
		link.sclk           = sclk_q;
		link.sync_n         = sync_q;
		link.din            = tx[WORD_W-1];
		link.clear_all_n    = pins_q[PIN_CLR_POS];
		link.load_outputs_n = pins_q[PIN_LOAD_POS];
		link.power_down_n   = pins_q[PIN_PD_POS];
	end
endmodule
`default_nettype wire

// File: qdsc_link_checker.sv
// Checks on the link pins between the host and device ends.
// Assumes the host divider runs with a half period of four clocks.
`timescale 1ns/1ns
`default_nettype none
module qdsc_link_checker (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic sclk,
	input  wire logic sync_n,
	input  wire logic din,
	input  wire logic clear_all_n,
	input  wire logic serial_out,
	input  wire logic serial_out_en,
	input  wire logic chain_enable_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	logic       sclk_q;      // Serial clock one cycle back
	logic [4:0] nfall;       // Falling edges seen in this frame
	logic [4:0] next_nfall;  // Next edge count

	// Count falls; frame select high empties the count
	always_comb begin
		next_nfall = nfall;
		if (sys_rst_i || sync_n) begin
			next_nfall = 5'h00;
		end else if (sclk_q && !sclk) begin
			next_nfall = nfall + 5'h01;
		end
	end

	// Registers only
	always_ff @(posedge clk_i) begin
		sclk_q <= sclk;
		nfall  <= next_nfall;
	end

	property p_idle; sync_n |-> sclk; endproperty
	a_idle: assert property (p_idle)
		else $error("serial clock low outside a frame");
	property p_gap; $rose(sync_n) |-> sync_n [*5]; endproperty
	a_gap: assert property (p_gap)
		else $error("frame select high time too short");
	property p_lead; $fell(sync_n) |-> sclk [*4] ##1 !sclk; endproperty
	a_lead: assert property (p_lead)
		else $error("first falling edge misplaced");
	property p_half; $fell(sclk) |-> !sclk [*4] ##1 sclk; endproperty
	a_half: assert property (p_half)
		else $error("serial clock half period wrong");
	property p_din; $fell(sclk) |-> $stable(din); endproperty
	a_din: assert property (p_din)
		else $error("data moved at sampling edge");
	property p_count; $rose(sync_n) |-> nfall == 5'h10; endproperty
	a_count: assert property (p_count)
		else $error("frame not sixteen edges long");
	property p_en; serial_out_en == chain_enable_i; endproperty
	a_en: assert property (p_en)
		else $error("output enable differs from chain mode");
	property p_alone; !chain_enable_i |-> !serial_out; endproperty
	a_alone: assert property (p_alone)
		else $error("serial output active in standalone mode");
	property p_so;
		chain_enable_i && $past(chain_enable_i) && clear_all_n &&
			$past(clear_all_n) && $changed(serial_out) |-> $rose(sclk);
	endproperty
	a_so: assert property (p_so)
		else $error("serial output moved off a rising edge");

	c_frame: cover property ($rose(sync_n));
	c_alone: cover property ($fell(sync_n) && !chain_enable_i);
	c_clear: cover property ($fell(clear_all_n));
endmodule
`default_nettype wire

// File: qdsc_link_if.sv
// Pins between the host controller and the quad converter.
// Assumes the host makes the serial clock; no wire is two-way.
`timescale 1ns/1ns
`default_nettype none
interface qdsc_link_if;
	logic sclk;            // Serial clock from the host
	logic sync_n;          // Frame select, active low
	logic din;             // Serial data into the device
	logic clear_all_n;     // Clear pin, active low
	logic load_outputs_n;  // Load pin, active low
	logic power_down_n;    // Power-down pin, active low
	logic serial_out;      // Serial data from the device
	logic serial_out_en;   // High while the device drives serial_out

	modport host (
		output sclk, sync_n, din, clear_all_n, load_outputs_n, power_down_n,
		input  serial_out, serial_out_en
	);
	modport device (
		input  sclk, sync_n, din, clear_all_n, load_outputs_n, power_down_n,
		output serial_out, serial_out_en
	);
endinterface
`default_nettype wire

// File: qdsc_pkg.sv
// Constants shared by the quad converter serial link, its device end and
// its host end. Assumes the host runs from a 100 MHz system clock.
package qdsc_pkg;
	// Serial word and channel layout
	localparam int WORD_W     = 16;               // Bits per serial word
	localparam int CH_N       = 4;                // Channels A to D
	localparam int CH_W       = 2;                // Channel-select width
	localparam int CODE_W_MAX = 12;               // Widest converter code
	localparam int CH_POS     = 14;               // Channel select, [15:14]
	localparam int BUF_POS    = 13;               // Reference buffer select
	localparam int GAIN_POS   = 12;               // Output range control
	localparam int DATA_MSB   = 11;               // Left-aligned code top

	// Edge counting in the device
	localparam int              CNT_W     = 5;
	localparam logic [CNT_W-1:0] BITS_ZERO = 5'h00; // Value after abort
	localparam logic [CNT_W-1:0] BITS_LAST = 5'h0F; // Before the 16th edge
	localparam logic [CNT_W-1:0] BITS_FULL = 5'h10; // 16 edges seen

	// Host timing
	localparam int CLK_HZ        = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_MAX_HZ   = 30_000_000;
	localparam int HALF_MIN_CYC  =
		(CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
	localparam int HALF_DEF_CYC  = 4;             // Half serial period
	localparam int SYNC_GAP_NS   = 50;            // Frame select high time
	localparam int SYNC_GAP_CYC  =
		(SYNC_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PH_W          = 4;             // Phase counter width

	// Host register map, byte addresses
	localparam int             ADDR_W   = 4;
	localparam logic [ADDR_W-1:0] OFF_WORD = 4'h0; // Word to send
	localparam logic [ADDR_W-1:0] OFF_PINS = 4'h4; // Control pin levels
	localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8; // Busy flag
	localparam logic [ADDR_W-1:0] OFF_RBK  = 4'hC; // Read-back word

	// Control pin register fields
	localparam int              PINS_W       = 3;
	localparam int              PIN_CLR_POS  = 0;
	localparam int              PIN_LOAD_POS = 1;
	localparam int              PIN_PD_POS   = 2;
	localparam logic [PINS_W-1:0] PINS_RST   = 3'h7; // All pins idle high

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Host sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} qdsc_state_t;
endpackage

// File: testbench.sv
// Self-checking bench: host and device joined by one link, a second
// device driven by hand for aborted and timed frames.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import qdsc_pkg::*;
	logic        clk_i, sys_rst_i, chain, ld_low;
	logic [3:0]  awaddr, araddr;
	logic [31:0] wdata, d, w0, w1;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, ib2;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata;
	logic [CH_N-1:0][CODE_W_MAX-1:0] code1, code2;
	logic [CH_N-1:0] buf1, gain1, oe1;
	int          fail_count, checks_done, cyc;
	int          in_m[4], dac_m[4];   // Input and converter models
	qdsc_link_if l1();                // Host to device link
	qdsc_link_if l2();                // Bench to second device

	qdsc_host i_qdsc_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .link(l1));
	qdsc_device i_qdsc_device (.link(l1), .chain_enable_i(chain),
		.dac_code_o(code1), .ref_buf_o(buf1), .gain_o(gain1),
		.out_en_o(oe1), .in_buf_on_o());
	// Second device stays standalone
	qdsc_device i_qdsc_device_2 (.link(l2), .chain_enable_i(1'b0),
		.dac_code_o(code2), .ref_buf_o(), .gain_o(), .out_en_o(),
		.in_buf_on_o(ib2));
	qdsc_link_checker i_qdsc_link_checker (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .sclk(l1.sclk), .sync_n(l1.sync_n),
		.din(l1.din), .clear_all_n(l1.clear_all_n),
		.serial_out(l1.serial_out), .serial_out_en(l1.serial_out_en),
		.chain_enable_i(chain));

	// System clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Cuts a hung handshake short
	initial begin
		cyc = 0;
		forever begin
			@(posedge clk_i);
			cyc++;
			if (cyc == 40000) begin
				fail_count++;
				report_and_stop();
			end
		end
	end

	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One write; each half released once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [3:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk_i);
	endtask

	// Pin levels, with their effect on the model
	task automatic pins(input logic [2:0] v);
		wr(OFF_PINS, {29'h0, v});
		ld_low = !v[1];
		if (!v[0]) begin
			in_m  = '{0, 0, 0, 0};
			dac_m = '{0, 0, 0, 0};
		end
		if (ld_low) dac_m = in_m;
	endtask

	// Word over the link; waits for busy to drop
	task automatic send(input logic [15:0] w);
		wr(OFF_WORD, {16'h0, w});
		do rd(OFF_STAT); while (d[0] !== 1'b0);
		in_m[w[15:14]] = w[13:0];
		if (ld_low) dac_m = in_m;
	endtask

	task automatic chk1();
		for (int c = 0; c < 4; c++) begin
			cmp("code", dac_m[c] & 32'hFFF, code1[c]);
			cmp("buf", dac_m[c] >> 13, buf1[c]);
			cmp("gain", (dac_m[c] >> 12) & 1, gain1[c]);
		end
	endtask

	// Hand-made frame of n bits at a 125 ns serial period
	task automatic frame2(input logic [15:0] w, input int n);
		l2.sync_n = 1'b0;
		#60;
		if (n == 16) cmp("inbuf", 1, ib2);
		for (int i = 0; i < n; i++) begin
			l2.din = w[15-i];
			#62 l2.sclk = 1'b0;
			#63 l2.sclk = 1'b1;
		end
		if (n == 16) cmp("inbuf", 0, ib2);
		#60 l2.sync_n = 1'b1;
		l2.din = ~l2.din;  // Released line shows no stale bit
		#100;
	endtask

	initial begin
		void'($urandom(41978));
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0;
		chain = 1'b1;
		ld_low = 1'b0;
		sys_rst_i = 1'b1;
		{l2.sclk, l2.sync_n, l2.din} = 3'h6;
		{l2.clear_all_n, l2.load_outputs_n, l2.power_down_n} = 3'h5;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFF_PINS);
		cmp("pins", {29'h0, PINS_RST}, d);
		pins(3'h6);
		pins(3'h7);
		chk1();
		for (int c = 0; c < 4; c++) begin
			send({c[1:0], 14'($urandom)});
			chk1();
		end
		pins(3'h5);
		pins(3'h7);
		chk1();
		pins(3'h5);
		w0 = {16'h0, 16'($urandom)};
		send(w0[15:0]);
		w1 = {16'h0, 16'($urandom)};
		send(w1[15:0]);
		chk1();
		// Word register keeps the last word sent
		rd(OFF_WORD);
		cmp("word", w1, d);
		rd(OFF_RBK);
		cmp("rbk", w0, d);
		pins(3'h4);
		pins(3'h5);
		chk1();
		pins(3'h1);
		cmp("oe", 0, oe1);
		pins(3'h5);
		cmp("oe", 32'hF, oe1);
		rd(4'h2);
		cmp("rresp", RESP_SLVERR, r);
		wr(4'h6, 32'h0);
		cmp("bresp", RESP_SLVERR, r);
		// Status is read-only: a write is ignored but answered OKAY
		wr(OFF_STAT, 32'h1);
		cmp("bresp", RESP_OKAY, r);
		chain <= 1'b0;
		send(16'($urandom));
		rd(OFF_RBK);
		cmp("rbk", 0, d);
		chk1();
		l2.clear_all_n = 1'b0;
		#100 l2.clear_all_n = 1'b1;
		w0 = {16'h0, 16'($urandom)};
		frame2(w0[15:0], 16);
		cmp("code2", w0 & 32'hFFF, code2[w0[15:14]]);
		w1 = w0 ^ 32'h3FFF;
		frame2(w1[15:0], 15);
		cmp("code2", w0 & 32'hFFF, code2[w0[15:14]]);
		report_and_stop();
	end
endmodule
`default_nettype wire
